// File: inc/roc_defs.svh
// Constants for the relay output conditioner
`ifndef ROC_DEFS_SVH
`define ROC_DEFS_SVH

`define ROC_CLK_HZ          40000000
`define ROC_TICK_PERIOD_MS  1
`define ROC_TICK_CYCLES     (`ROC_CLK_HZ / 1000 * `ROC_TICK_PERIOD_MS)

`define ROC_CH_STRIDE       8'h10
`define ROC_OFS_ASSIGN      8'h00
`define ROC_OFS_DELAY       8'h04
`define ROC_OFS_HOLD        8'h08
`define ROC_OFS_POLARITY    8'h0C
`define ROC_OFS_STATUS      8'h20

`define ROC_SEL_NONE        8'h00
`define ROC_SEL_NO_FAULT    8'h01
`define ROC_SEL_OUT_CONT    8'h02
`define ROC_SEL_DC_PRE      8'h03
`define ROC_SEL_LINE_CONT   8'h04
`define ROC_SEL_GEN_BASE    8'h10
`define ROC_SEL_GEN_LAST    8'h1B
`define ROC_GEN_COUNT       12

`define ROC_DELAY_MAX       16'hEA60
`define ROC_HOLD_MAX        16'h270F
`define ROC_DELAY_RESET     16'h0000
`define ROC_HOLD_RESET      16'h0000
`define ROC_POL_RESET       1'b1

`define ROC_STAT_CARD_LSB   0
`define ROC_STAT_COIL_LSB   2
`define ROC_STAT_ACT_LSB    4

`endif

// File: inc/roc_pkg.sv
// Types for the relay output conditioner
package roc_pkg;

    typedef enum logic [1:0] {
        ROC_IDLE,
        ROC_ON_WAIT,
        ROC_ACTIVE,
        ROC_OFF_WAIT
    } roc_state_type;

endpackage : roc_pkg

// File: src/roc_timer.sv
// Turn-on delay and holding time sequencer for one relay
`include "roc_defs.svh"

module roc_timer (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic [15:0] delay,
    input  wire logic [15:0] hold,
    output logic             active
);

    roc_pkg::roc_state_type state;
    roc_pkg::roc_state_type next_state;
    logic [15:0]            count;
    logic [15:0]            next_count;
    logic                   next_active;

    // Counting until count reaches the limit on a tick guarantees the full time, up to 1 ms more
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            roc_pkg::ROC_IDLE: begin
                if (cond) begin
                    next_count = 16'h0000;
                    next_state = (delay == 16'h0000) ? roc_pkg::ROC_ACTIVE : roc_pkg::ROC_ON_WAIT;
                end
            end
            roc_pkg::ROC_ON_WAIT: begin
                if (!cond) begin
                    next_state = roc_pkg::ROC_IDLE;
                end else if (tick) begin
                    if (count >= delay) begin
                        next_state = roc_pkg::ROC_ACTIVE;
                    end else begin
                        next_count = count + 16'h0001;
                    end
                end
            end
            roc_pkg::ROC_ACTIVE: begin
                if (!cond) begin
                    next_count = 16'h0000;
                    next_state = (hold == 16'h0000) ? roc_pkg::ROC_IDLE : roc_pkg::ROC_OFF_WAIT;
                end
            end
            roc_pkg::ROC_OFF_WAIT: begin
                if (cond) begin
                    next_state = roc_pkg::ROC_ACTIVE;
                end else if (tick) begin
                    if (count >= hold) begin
                        next_state = roc_pkg::ROC_IDLE;
                    end else begin
                        next_count = count + 16'h0001;
                    end
                end
            end
            default: begin
                next_state = roc_pkg::ROC_IDLE;
                next_count = 16'h0000;
            end
        endcase
        next_active = (next_state == roc_pkg::ROC_ACTIVE) || (next_state == roc_pkg::ROC_OFF_WAIT);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state  <= roc_pkg::ROC_IDLE;
            count  <= 16'h0000;
            active <= 1'b0;
        end else begin
            state  <= next_state;
            count  <= next_count;
            active <= next_active;
        end
    end

endmodule : roc_timer

// File: src/roc_top.sv
// Relay output conditioner: APB registers, millisecond tick and two relay channels
`include "roc_defs.svh"

module roc_top #(
    parameter int TICK_CYCLES = `ROC_TICK_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [1:0]  CARD_PRESENT,
    input  wire logic        NO_FAULT,
    input  wire logic        OUTPUT_CONTACTOR_CMD,
    input  wire logic        DC_PRECHARGE_CMD,
    input  wire logic        LINE_CONTACTOR_CMD,
    input  wire logic [11:0] STATUS_COND,
    output wire logic [1:0]  RELAY_COIL
);

    logic [15:0] tick_count;
    logic [15:0] next_tick_count;
    logic        tick;
    logic        next_tick;
    logic [1:0]  card_meta;
    logic [1:0]  card_sync;
    logic [1:0]  ch_hit;
    logic [1:0]  ch_bad;
    logic [1:0]  ch_active;
    logic [1:0]  ch_coil;
    logic [1:0][31:0] ch_rdata;
    logic        status_hit;
    logic        wr_en;
    logic        setup;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // Delay is fixed at zero for these
    function automatic logic lock_delay(input logic [7:0] sel);
        lock_delay = (sel == `ROC_SEL_NO_FAULT) || (sel == `ROC_SEL_OUT_CONT) ||
                     (sel == `ROC_SEL_DC_PRE) || (sel == `ROC_SEL_LINE_CONT);
    endfunction : lock_delay

    // Holding time and polarity are fixed for these
    function automatic logic lock_hold(input logic [7:0] sel);
        lock_hold = (sel == `ROC_SEL_NO_FAULT) || (sel == `ROC_SEL_DC_PRE) ||
                    (sel == `ROC_SEL_LINE_CONT);
    endfunction : lock_hold

    function automatic logic sel_valid(input logic [7:0] sel);
        sel_valid = (sel <= `ROC_SEL_LINE_CONT) ||
                    ((sel >= `ROC_SEL_GEN_BASE) && (sel <= `ROC_SEL_GEN_LAST));
    endfunction : sel_valid

    function automatic logic sel_cond(input logic [7:0] sel, input logic [15:0] conds);
        logic [7:0] idx;
        idx = sel - `ROC_SEL_GEN_BASE;
        case (sel)
            `ROC_SEL_NO_FAULT:  sel_cond = conds[0];
            `ROC_SEL_OUT_CONT:  sel_cond = conds[1];
            `ROC_SEL_DC_PRE:    sel_cond = conds[2];
            `ROC_SEL_LINE_CONT: sel_cond = conds[3];
            default: begin
                if ((sel >= `ROC_SEL_GEN_BASE) && (sel <= `ROC_SEL_GEN_LAST)) begin
                    sel_cond = conds[4 + idx[3:0]];
                end else begin
                    sel_cond = 1'b0;
                end
            end
        endcase
    endfunction : sel_cond

    // Millisecond tick shared by both channels
    always_comb begin
        next_tick = 1'b0;
        next_tick_count = tick_count + 16'h0001;
        if (tick_count >= 16'(TICK_CYCLES - 1)) begin
            next_tick_count = 16'h0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tick_count <= 16'h0000;
            tick       <= 1'b0;
        end else begin
            tick_count <= next_tick_count;
            tick       <= next_tick;
        end
    end

    // Card presence pins are asynchronous to CLK
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            card_meta <= 2'h0;
            card_sync <= 2'h0;
        end else begin
            card_meta <= CARD_PRESENT;
            card_sync <= card_meta;
        end
    end

    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE && PREADY;

    for (genvar g = 0; g < 2; g++) begin : gen_ch
        localparam logic [7:0] BASE = 8'(g * `ROC_CH_STRIDE);
        logic [7:0]  sel;
        logic [7:0]  next_sel;
        logic [15:0] delay;
        logic [15:0] next_delay;
        logic [15:0] hold;
        logic [15:0] next_hold;
        logic        pol;
        logic        next_pol;
        logic        coil;
        logic        next_coil;
        logic        cond;
        logic        hit_sel;
        logic        hit_delay;
        logic        hit_hold;
        logic        hit_pol;

        assign hit_sel   = PADDR == BASE + `ROC_OFS_ASSIGN;
        assign hit_delay = PADDR == BASE + `ROC_OFS_DELAY;
        assign hit_hold  = PADDR == BASE + `ROC_OFS_HOLD;
        assign hit_pol   = PADDR == BASE + `ROC_OFS_POLARITY;
        assign ch_hit[g] = hit_sel || hit_delay || hit_hold || hit_pol;
        // Out-of-range values are refused with an error, not clamped
        assign ch_bad[g] = (hit_sel && !sel_valid(PWDATA[7:0])) || (PWDATA[31:16] != 16'h0000) ||
                           (hit_delay && (PWDATA[15:0] > `ROC_DELAY_MAX)) ||
                           (hit_hold && (PWDATA[15:0] > `ROC_HOLD_MAX));
        assign cond = sel_cond(sel, {STATUS_COND, LINE_CONTACTOR_CMD, DC_PRECHARGE_CMD,
                                     OUTPUT_CONTACTOR_CMD, NO_FAULT});

        always_comb begin
            next_sel   = sel;
            next_delay = delay;
            next_hold  = hold;
            next_pol   = pol;
            if (!card_sync[g]) begin
                // Settings fall back to defaults while the card is missing
                next_sel   = `ROC_SEL_NONE;
                next_delay = `ROC_DELAY_RESET;
                next_hold  = `ROC_HOLD_RESET;
                next_pol   = `ROC_POL_RESET;
            end else if (wr_en && ch_hit[g] && !ch_bad[g]) begin
                if (hit_sel) begin
                    next_sel = PWDATA[7:0];
                end
                if (hit_delay && !lock_delay(sel)) begin
                    next_delay = PWDATA[15:0];
                end
                if (hit_hold && !lock_hold(sel)) begin
                    next_hold = PWDATA[15:0];
                end
                if (hit_pol && !lock_hold(sel)) begin
                    next_pol = PWDATA[0];
                end
            end
            if (lock_delay(next_sel)) begin
                next_delay = 16'h0000;
            end
            if (lock_hold(next_sel)) begin
                next_hold = 16'h0000;
                next_pol  = 1'b1;
            end
            // No card, no coil drive regardless of polarity
            next_coil = card_sync[g] && (pol ? ch_active[g] : !ch_active[g]);
        end

        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                sel   <= `ROC_SEL_NONE;
                delay <= `ROC_DELAY_RESET;
                hold  <= `ROC_HOLD_RESET;
                pol   <= `ROC_POL_RESET;
                coil  <= 1'b0;
            end else begin
                sel   <= next_sel;
                delay <= next_delay;
                hold  <= next_hold;
                pol   <= next_pol;
                coil  <= next_coil;
            end
        end

        roc_timer u_timer (
            .clk    (CLK),
            .resetn (RESETN),
            .tick   (tick),
            .cond   (cond),
            .delay  (delay),
            .hold   (hold),
            .active (ch_active[g])
        );

        assign ch_coil[g]    = coil;
        assign RELAY_COIL[g] = coil;
        assign ch_rdata[g]   = !card_sync[g] ? 32'h0000_0000 :
                               hit_sel   ? {24'h00_0000, sel} :
                               hit_delay ? {16'h0000, delay} :
                               hit_hold  ? {16'h0000, hold} :
                               hit_pol   ? {31'h0000_0000, pol} : 32'h0000_0000;
    end

    assign status_hit = PADDR == `ROC_OFS_STATUS;

    // Answer prepared in setup so PREADY, PRDATA and PSLVERR all come from flops
    always_comb begin
        next_pready  = setup;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (setup) begin
            if (status_hit) begin
                next_prdata[`ROC_STAT_CARD_LSB +: 2] = card_sync;
                next_prdata[`ROC_STAT_COIL_LSB +: 2] = ch_coil;
                next_prdata[`ROC_STAT_ACT_LSB +: 2]  = ch_active;
            end else if (ch_hit[0]) begin
                next_prdata = ch_rdata[0];
            end else if (ch_hit[1]) begin
                next_prdata = ch_rdata[1];
            end
            next_pslverr = !(status_hit || (|ch_hit)) || (PWRITE && (|(ch_bad & ch_hit)));
            if (PWRITE) begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA  <= next_prdata;
            PREADY  <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

endmodule : roc_top

// File: verif/roc_relay_model.sv
// Relay contact model counting contact changes
module roc_relay_model (
    input  wire logic CLK,
    input  wire logic COIL,
    output logic      contact,
    output int        switches
);
    initial begin
        contact = 1'b0;
        switches = 0;
    end
    // Contact follows the coil one clock late, like a slow armature
    always @(posedge CLK) begin
        if (contact !== COIL) switches <= switches + 1;
        contact <= COIL;
    end
endmodule : roc_relay_model

// File: verif/roc_top_checker.sv
// Port assertions for the relay output conditioner
module roc_top_checker #(
    parameter int TICK_CYCLES = 40000
) (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [1:0]  CARD_PRESENT,
    input wire logic        NO_FAULT,
    input wire logic        OUTPUT_CONTACTOR_CMD,
    input wire logic        DC_PRECHARGE_CMD,
    input wire logic        LINE_CONTACTOR_CMD,
    input wire logic [11:0] STATUS_COND,
    input wire logic [1:0]  RELAY_COIL
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("ready missing");
    a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready too long");
    a_ready_cause: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
    a_err_in_access: assert property (PSLVERR |-> PREADY) else $error("error outside access");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data not cleared");
    a_err_unmapped: assert property (PREADY && (PADDR > 8'h20 || PADDR[1:0] != 2'h0) |-> PSLVERR)
        else $error("unmapped not refused");
    a_delay_range: assert property (PREADY && PWRITE && PADDR[3:0] == 4'h4 && !PADDR[5]
        && CARD_PRESENT[PADDR[4]] && PWDATA > 32'hEA60 |-> PSLVERR) else $error("delay range");
    a_hold_range: assert property (PREADY && PWRITE && PADDR[3:0] == 4'h8 && !PADDR[5]
        && CARD_PRESENT[PADDR[4]] && PWDATA > 32'h270F |-> PSLVERR) else $error("hold range");
    a_coil_no_card: assert property (!CARD_PRESENT[1] [*5] |-> !RELAY_COIL[1]) else $error("coil without card");
    a_reset_quiet: assert property (disable iff (1'b0) !RESETN |-> RELAY_COIL == 2'h0 && !PREADY)
        else $error("outputs active in reset");
endmodule : roc_top_checker

bind roc_top roc_top_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);

// File: verif/roc_top_test.sv
// Self-checking testbench for the relay output conditioner
module roc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        nf, oc, dp, lc, contact;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  card, coil;
    logic [11:0] stat;
    int          error_cnt, total_checks, switches;

    roc_top #(.TICK_CYCLES(T)) uut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CARD_PRESENT(card), .NO_FAULT(nf), .OUTPUT_CONTACTOR_CMD(oc),
        .DC_PRECHARGE_CMD(dp), .LINE_CONTACTOR_CMD(lc), .STATUS_COND(stat), .RELAY_COIL(coil));
    roc_relay_model relay (.CLK(clk), .COIL(coil[0]), .contact(contact), .switches(switches));

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, x);
        end
    endtask : chk

    // Master holds the request until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait-state limit here; a hung slave is left to the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk(e, ee);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk(e, 32'h0);
    endtask : rd

    // Counts falling edges until the coil reaches the level
    task automatic wait_coil(input int b, input logic lv, input int lo, input int hi);
        int n;
        n = 0;
        while (coil[b] !== lv && n <= hi) begin
            @(negedge clk);
            n++;
        end
        chk(n >= lo && n <= hi, 32'h1);
    endtask : wait_coil

    task automatic t_defaults();
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h1);
        rd(8'h1C, 32'h0);
        wr(8'h24, 32'h0, 1'b1);
        wr(8'h00, 32'h05, 1'b1);
        wr(8'h00, 32'h1C, 1'b1);
    endtask : t_defaults

    task automatic t_range();
        wr(8'h04, 32'hEA60, 1'b0);
        wr(8'h04, 32'hEA61, 1'b1);
        rd(8'h04, 32'hEA60);
        wr(8'h08, 32'h270F, 1'b0);
        wr(8'h08, 32'h2710, 1'b1);
        rd(8'h08, 32'h270F);
    endtask : t_range

    task automatic t_timing();
        int sw;
        wr(8'h00, 32'h10, 1'b0);
        wr(8'h04, 32'h3, 1'b0);
        wr(8'h08, 32'h2, 1'b0);
        @(posedge clk) stat[0] <= 1'b1;
        wait_coil(0, 1'b1, 3 * T + 2, 4 * T + 4);
        @(posedge clk) stat[0] <= 1'b0;
        wait_coil(0, 1'b0, 2 * T + 2, 3 * T + 4);
        @(posedge clk) stat[0] <= 1'b1;
        repeat (2 * T) @(posedge clk);
        // Relay model counts the fall one clock late, so sample only now
        sw = switches;
        stat[0] <= 1'b0;
        @(posedge clk) stat[0] <= 1'b1;
        wait_coil(0, 1'b1, 3 * T + 2, 4 * T + 4);
        repeat (2) @(negedge clk);
        chk(switches - sw, 32'h1);
        wr(8'h04, 32'h0, 1'b0);
        wr(8'h08, 32'h0, 1'b0);
        @(posedge clk) stat[0] <= 1'b0;
        wait_coil(0, 1'b0, 3, 3);
        wr(8'h0C, 32'h0, 1'b0);
        wait_coil(0, 1'b1, 0, 6);
        @(posedge clk) stat[0] <= 1'b1;
        wait_coil(0, 1'b0, 3, 3);
        @(posedge clk) stat[0] <= 1'b0;
    endtask : t_timing

    // Locked assignments ignore delay writes; all but the output contactor also ignore hold and polarity writes
    task automatic t_locked();
        logic lk;
        for (int c = 1; c <= 4; c++) begin
            lk = (c != 2);
            wr(8'h00, c, 1'b0);
            wr(8'h04, 32'h5, 1'b0);
            wr(8'h08, 32'h7, 1'b0);
            wr(8'h0C, 32'h0, 1'b0);
            rd(8'h04, 32'h0);
            rd(8'h08, lk ? 32'h0 : 32'h7);
            rd(8'h0C, lk);
            wait_coil(0, lk, 0, 3);
        end
        for (int g = 0; g < 12; g++) begin
            wr(8'h00, 32'h10 + g, 1'b0);
            wait_coil(0, 1'b0, 0, 3);
            @(posedge clk) stat <= 12'h1 << g;
            wait_coil(0, 1'b1, 3, 3);
            @(posedge clk) stat <= 12'h0;
            wait_coil(0, 1'b0, 3, 3);
        end
    endtask : t_locked

    task automatic t_card();
        @(posedge clk) card[1] <= 1'b1;
        repeat (4) @(posedge clk);
        wr(8'h10, 32'h1B, 1'b0);
        rd(8'h10, 32'h1B);
        rd(8'h20, 32'h3);
        @(posedge clk) stat[11] <= 1'b1;
        wait_coil(1, 1'b1, 3, 3);
        @(posedge clk) card[1] <= 1'b0;
        wait_coil(1, 1'b0, 1, 5);
        rd(8'h10, 32'h0);
    endtask : t_card

    // Reset in mid-run must drop the coils and restore default settings
    task automatic t_reset();
        @(posedge clk) resetn <= 1'b0;
        repeat (3) @(posedge clk);
        chk(coil, 32'h0);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h1);
    endtask : t_reset

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {nf, oc, dp, lc} = 4'hF;
        card = 2'h1;
        stat = 12'h0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_defaults();
        t_range();
        t_timing();
        t_locked();
        t_card();
        t_reset();
        summarize();
    end

    // Whole run is a few hundred clocks; this is ample margin
    initial begin
        #500us;
        error_cnt++;
        summarize();
    end
endmodule : roc_top_test
